/* File: verilog/lcdcd_pkg.sv */
package lcdcd_pkg;
  // Opcodes with bit 0 masked off where bit 0 carries the option.
  localparam logic [7:0] OP_DISP = 8'h00_ae;
  localparam logic [7:0] OP_ORDER = 8'h00_a0;
  localparam logic [7:0] OP_STATIC = 8'h00_a4;
  localparam logic [7:0] OP_DUTY = 8'h00_a8;
  localparam logic [7:0] OP_RMW = 8'h00_e0;
  localparam logic [7:0] OP_END = 8'h00_ee;
  localparam logic [7:0] OP_SOFT_RESET = 8'h00_e2;
  // Start line commands occupy 8'hc0 to 8'hdf.
  localparam logic [2:0] OP_LINE_TOP = 3'h6;
  // Page commands occupy 8'hb8 to 8'hbb.
  localparam logic [5:0] OP_PAGE_TOP = 6'h2e;
  // Sizes and limits of the addressing.
  localparam int COL_W = 7;
  localparam int LINE_W = 5;
  localparam int PAGE_W = 2;
  localparam logic [6:0] COL_LIMIT = 7'h50;
  localparam logic [6:0] COL_LAST = 7'h4f;
  localparam int RAM_DEPTH = 320;
  // Reset values.
  localparam logic [4:0] LINE_RESET = 5'h01;
  localparam logic [6:0] COL_RESET = 7'h00;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  // Status bit positions.
  localparam int ST_BUSY = 7;
  localparam int ST_ORDER = 6;
  localparam int ST_OFF = 5;
  localparam int ST_RESET = 4;
  // Execution time of a command and of reset, in mclk cycles.
  localparam int CMD_TIME_NS = 10;
  localparam int CLK_NS = 5;
  localparam logic [3:0] CMD_CYCLES = 4'((CMD_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RST_CYCLES = 4'h4;
  // Mode flags carried together.
  typedef struct packed {
    logic disp_on;
    logic static_on;
    logic duty_quarter;
    logic order_fwd;
    logic rmw_on;
  } lcdcd_mode_type;
  // One host bus access as seen after sampling.
  typedef struct packed {
    logic rs;
    logic rd;
    logic [7:0] data;
  } lcdcd_acc_type;
endpackage

/* File: verilog/lcdcd_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin levels.
module lcdcd_sync
  import lcdcd_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage; only the second stage reads it.
  logic [W-1:0] meta_r;

  // Both stages clear on reset to a constant.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // lcdcd_sync

/* File: verilog/lcdcd_ram.sv */
`timescale 1ns/1ps
// Display RAM, one byte per page and column, with a registered read.
module lcdcd_ram
  import lcdcd_pkg::*;
(
  input wire logic mclk,
  input wire logic we,
  input wire logic re,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // Storage array; contents are undefined until written.
  logic [7:0] mem [RAM_DEPTH];

  // Writes and reads both land on the clock edge.
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[addr];
    end
  end
endmodule // lcdcd_ram

/* File: verilog/lcdcd_top.sv */
`timescale 1ns/1ps
// Operation
// - Reset sets line one, column and page zero.
// - Reset: display off, static off, quarter duty, forward.
// - Soft reset touches line, column, page and the reset flag.
// - Init pin level selects 68 or 80 bus.
// - Display command bit 0 switches display.
// - Start-line command loads five-bit line address.
// - Display window starts at start line upward.
// - Page command loads two bits, display unaffected.
// - Bit 7 clear loads seven-bit column.
// - Column increments per access, stops at limit.
// - Status: busy, order, off, reset flags.
// - Busy while executing; new commands refused.
// - Order flag maps column n or 79-n.
// - Order command bit 0 selects reverse.
// - Static command bit 0 enables static drive.
// - Duty command bit 0 selects quarter duty.
// - Read-modify-write increments on writes only.
// - End command restores normal increment.
// - Static on with display off: power save.
// - Data write stores byte, increments column.
// - Data read returns latch, refills, increments.
// - End restores column saved at mode entry.
// - While busy only status read accepted.
// - 80 style: drive on read, latch write.
module lcdcd_top
  import lcdcd_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic init_pin,
  input wire logic cs_n,
  input wire logic reg_select_line,
  input wire logic strobe_e_rd,
  input wire logic rw_wr,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_n,
  output logic [4:0] first_row_line,
  output logic [4:0] row_span,
  output logic disp_on,
  output logic static_on,
  output logic power_save,
  output logic order_fwd,
  output logic [1:0] page_out
);
  // Synchronised copies of all bus pins.
  logic [12:0] pins_s;
  logic init_s;
  logic cs_s;
  logic rs_s;
  logic e_s;
  logic rw_s;
  logic [7:0] db_s;
  // Bus style: 1 means 80-series, 0 means 68-series.
  logic style80_r;
  logic style_set_r; // Set once the style has been taken after reset.
  logic [1:0] settle_r; // Fills as the sync stages fill after reset.
  // Previous strobe level for edge detection.
  logic e_d_r;
  logic rw_d_r;
  // Decoded strobe events.
  logic rd_go;
  logic wr_go;
  logic rd_active;
  // Registers of the decoder.
  lcdcd_mode_type mode_r;
  logic [4:0] line_r;
  logic [6:0] col_r;
  logic [6:0] col_save_r;
  logic [1:0] page_r;
  logic [3:0] busy_cnt_r;
  logic reset_busy_r;
  logic [7:0] latch_r;
  logic fill_pend_r;
  // Internal reset request caught from the init pin level.
  logic init_act;
  // Accepted access of this cycle.
  lcdcd_acc_type acc;
  logic cmd_ok;
  logic [7:0] op;
  // RAM port signals.
  logic ram_we;
  logic ram_re;
  logic [7:0] ram_q;
  // Returns the RAM address for a page and column.
  function automatic logic [8:0] ram_addr(input logic [1:0] pg, input logic [6:0] c);
    ram_addr = 9'(pg * COL_LIMIT + c);
  endfunction
  // Advances a column, holding it at the upper limit.
  function automatic logic [6:0] col_step(input logic [6:0] c);
    col_step = (c >= COL_LIMIT) ? c : 7'(c + 7'h01);
  endfunction
  // All pins come from the host's domain, so they pass two flops first.
  lcdcd_sync #(.W(13)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d({init_pin, cs_n, reg_select_line, strobe_e_rd, rw_wr, db_in}),
    .q(pins_s)
  );
  assign {init_s, cs_s, rs_s, e_s, rw_s, db_s} = pins_s;
  // The style is taken once from the settled resting level of the init pin.
  // A low level means an 80-style host, whose reset pulse is active high.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      style80_r <= 1'b0;
      style_set_r <= 1'b0;
      settle_r <= 2'h0;
    end
    else
    begin
      settle_r <= {settle_r[0], 1'b1};
      if (settle_r[1] && !style_set_r)
      begin
        style80_r <= ~init_s;
        style_set_r <= 1'b1;
      end
    end
  end
  // Active-high reset for the 80 style, active-low for the 68 style.
  assign init_act = style_set_r && (style80_r ? init_s : ~init_s);
  // Strobe history for edge detection.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      e_d_r <= 1'b1;
      rw_d_r <= 1'b1;
    end
    else
    begin
      e_d_r <= e_s;
      rw_d_r <= rw_s;
    end
  end
  // Falling strobes for 80 style; 68 reads on E rise so data stands while E is high.
  always_comb
  begin
    if (style80_r)
    begin
      rd_go = style_set_r && !cs_s && !e_s && e_d_r;
      wr_go = style_set_r && !cs_s && !rw_s && rw_d_r;
      rd_active = !cs_s && !e_s;
    end
    else
    begin
      rd_go = style_set_r && !cs_s && e_s && !e_d_r && rw_s;
      wr_go = style_set_r && !cs_s && !e_s && e_d_r && !rw_s;
      rd_active = !cs_s && e_s && rw_s;
    end
  end
  // The access seen this cycle.
  assign acc = '{rs: rs_s, rd: rd_go, data: db_s};
  assign op = acc.data;
  // Commands and data accesses are taken only when not busy.
  assign cmd_ok = (busy_cnt_r == 4'h0) && !init_act;
  // Busy counter: loaded by a command, a data write or read, or reset, counts down to ready.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_cnt_r <= RST_CYCLES;
      reset_busy_r <= 1'b1;
    end
    else if (init_act)
    begin
      busy_cnt_r <= RST_CYCLES;
      reset_busy_r <= 1'b1;
    end
    else if (cmd_ok && wr_go && !acc.rs && op == OP_SOFT_RESET)
    begin
      busy_cnt_r <= CMD_CYCLES;
      reset_busy_r <= 1'b1;
    end
    else if (cmd_ok && (wr_go || (rd_go && acc.rs)))
    begin
      busy_cnt_r <= CMD_CYCLES;
    end
    else if (busy_cnt_r != 4'h0)
    begin
      busy_cnt_r <= 4'(busy_cnt_r - 4'h1);
    end
    else
    begin
      reset_busy_r <= 1'b0;
    end
  end
  // Mode flags: only the pin reset clears them, never the soft reset.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_r <= '{disp_on: 1'b0, static_on: 1'b0, duty_quarter: 1'b1,
                  order_fwd: 1'b1, rmw_on: 1'b0};
    end
    else if (init_act)
    begin
      mode_r <= '{disp_on: 1'b0, static_on: 1'b0, duty_quarter: 1'b1,
                  order_fwd: 1'b1, rmw_on: 1'b0};
    end
    else if (cmd_ok && wr_go && !acc.rs)
    begin
      // Opcodes with no match fall through unchanged.
      case ({op[7:1], 1'b0})
        OP_DISP: mode_r.disp_on <= op[0];
        OP_ORDER: mode_r.order_fwd <= ~op[0];
        OP_STATIC: mode_r.static_on <= op[0];
        OP_DUTY: mode_r.duty_quarter <= op[0];
        OP_RMW: mode_r.rmw_on <= (op[0]) ? mode_r.rmw_on : 1'b1;
        OP_END: mode_r.rmw_on <= (op[0]) ? mode_r.rmw_on : 1'b0;
        default: mode_r <= mode_r;
      endcase
    end
  end
  // Start line and page; both soft reset and pin reset reinitialise them.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_r <= LINE_RESET;
      page_r <= PAGE_RESET;
    end
    else if (init_act)
    begin
      line_r <= LINE_RESET;
      page_r <= PAGE_RESET;
    end
    else if (cmd_ok && wr_go && !acc.rs)
    begin
      if (op == OP_SOFT_RESET)
      begin
        line_r <= LINE_RESET;
        page_r <= PAGE_RESET;
      end
      else if (op[7:5] == OP_LINE_TOP)
      begin
        line_r <= op[4:0];
      end
      else if (op[7:2] == OP_PAGE_TOP)
      begin
        page_r <= op[1:0];
      end
    end
  end
  // Column counter with auto-increment and the saved copy for the end command.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      col_r <= COL_RESET;
      col_save_r <= COL_RESET;
    end
    else if (init_act)
    begin
      col_r <= COL_RESET;
    end
    else if (cmd_ok && wr_go && !acc.rs)
    begin
      if (op == OP_SOFT_RESET)
      begin
        col_r <= COL_RESET;
      end
      else if (!op[7])
      begin
        col_r <= op[6:0];
      end
      else if (op == OP_RMW && !mode_r.rmw_on)
      begin
        col_save_r <= col_r;
      end
      else if (op == OP_END && mode_r.rmw_on)
      begin
        col_r <= col_save_r;
      end
    end
    else if (cmd_ok && wr_go && acc.rs)
    begin
      col_r <= col_step(col_r);
    end
    else if (cmd_ok && rd_go && acc.rs && !mode_r.rmw_on)
    begin
      col_r <= col_step(col_r);
    end
  end
  // RAM accesses: writes store at page and column, reads refill the latch.
  assign ram_we = cmd_ok && wr_go && acc.rs && (col_r < COL_LIMIT);
  assign ram_re = cmd_ok && rd_go && acc.rs;
  lcdcd_ram u_ram (
    .mclk(mclk),
    .we(ram_we),
    .re(ram_re),
    .addr(ram_addr(page_r, (col_r < COL_LIMIT) ? col_r : COL_LAST)),
    .wdata(acc.data),
    .rdata(ram_q)
  );
  // Refilled a cycle after the RAM read, so the first read after a column load is a dummy.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fill_pend_r <= 1'b0;
      latch_r <= 8'h00_00;
    end
    else
    begin
      fill_pend_r <= ram_re;
      if (fill_pend_r)
      begin
        latch_r <= ram_q;
      end
    end
  end
  // Bus output: status or latched data, driven only during a read.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      db_out <= 8'h00_00;
      db_oe_n <= 1'b1;
    end
    else
    begin
      db_oe_n <= ~rd_active;
      if (rd_go)
      begin
        if (rs_s)
        begin
          db_out <= latch_r;
        end
        else
        begin
          db_out <= 8'h00_00;
          db_out[ST_BUSY] <= (busy_cnt_r != 4'h0) || init_act;
          db_out[ST_ORDER] <= mode_r.order_fwd;
          db_out[ST_OFF] <= ~mode_r.disp_on;
          db_out[ST_RESET] <= reset_busy_r;
        end
      end
    end
  end
  // Display-side outputs: window start, span, mapping and power save.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_row_line <= LINE_RESET;
      row_span <= 5'h04;
      disp_on <= 1'b0;
      static_on <= 1'b0;
      power_save <= 1'b0;
      order_fwd <= 1'b1;
      page_out <= PAGE_RESET;
    end
    else
    begin
      first_row_line <= line_r;
      row_span <= mode_r.duty_quarter ? 5'h04 : 5'h03;
      disp_on <= mode_r.disp_on;
      static_on <= mode_r.static_on;
      power_save <= mode_r.static_on && !mode_r.disp_on;
      order_fwd <= mode_r.order_fwd;
      page_out <= page_r;
    end
  end
endmodule // lcdcd_top

/* File: dv/lcdcd_chk.sv */
`timescale 1ns/1ps
// Watches the host bus pins and the mode outputs of the decoder.
module lcdcd_chk
  import lcdcd_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic init_pin,
  input wire logic cs_n,
  input wire logic reg_select_line,
  input wire logic strobe_e_rd,
  input wire logic rw_wr,
  input wire logic [7:0] db_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe_n,
  input wire logic [4:0] first_row_line,
  input wire logic [4:0] row_span,
  input wire logic disp_on,
  input wire logic static_on,
  input wire logic power_save,
  input wire logic order_fwd,
  input wire logic [1:0] page_out
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Command write in progress; its rise marks the strobe edge.
  logic cmd_w;
  assign cmd_w = !cs_n && !reg_select_line && !rw_wr;
  // Values seen at the first edge after reset.
  property p_rst;
    $rose(arst_n) |-> first_row_line == LINE_RESET && page_out == PAGE_RESET
      && !disp_on && !static_on && order_fwd && row_span == 5'h4;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  // The window allows for the two sync flops and the update.
  property p_disp;
    $rose(cmd_w) && db_in == 8'haf |-> ##[2:6] disp_on;
  endproperty
  a_disp: assert property (p_disp) else $error("display on missed");
  property p_rev;
    $rose(cmd_w) && db_in == 8'ha1 |-> ##[2:6] !order_fwd;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse order missed");
  // Data is still held by the host when the consequent is checked.
  property p_line;
    $rose(cmd_w) && db_in[7:5] == OP_LINE_TOP |-> ##[2:6] first_row_line == db_in[4:0];
  endproperty
  a_line: assert property (p_line) else $error("start line not loaded");
  property p_page;
    $rose(cmd_w) && db_in[7:2] == OP_PAGE_TOP |-> ##[2:6] page_out == db_in[1:0];
  endproperty
  a_page: assert property (p_page) else $error("page not loaded");
  property p_soft;
    $rose(cmd_w) && db_in == OP_SOFT_RESET |-> ##[2:8]
      first_row_line == LINE_RESET && page_out == PAGE_RESET;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_ps;
    (static_on && !disp_on) [*3] |-> power_save;
  endproperty
  a_ps: assert property (p_ps) else $error("power save missing");
  // Only the 80 style, picked by a low resting init level, reads on a low strobe.
  property p_oe;
    (!init_pin && !cs_n && !strobe_e_rd) [*4] |-> !db_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("bus not driven on read");
  // Read data only moves after a read strobe.
  property p_hold;
    strobe_e_rd [*5] |-> $stable(db_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pg;
    (!cs_n && reg_select_line) [*6] |-> $stable(page_out);
  endproperty
  a_pg: assert property (p_pg) else $error("page moved on data access");
endmodule // lcdcd_chk

bind lcdcd_top lcdcd_chk i_chk (.*);

/* File: dv/lcdcd_host.sv */
`timescale 1ns/1ps
// Host on the 80-style bus, with a 68-style task too; pacing is far slower than the sync delay needs.
module lcdcd_host
(
  input wire logic mclk,
  input wire logic [7:0] db_out,
  output logic init_pin,
  output logic cs_n,
  output logic reg_select_line,
  output logic strobe_e_rd,
  output logic rw_wr,
  output logic [7:0] db_in
);
  // A low resting pin level picks the 80-style strobes.
  initial
  begin
    init_pin = 1'b0;
    cs_n = 1'b1;
    reg_select_line = 1'b0;
    strobe_e_rd = 1'b1;
    rw_wr = 1'b1;
    db_in = 8'h5a;
  end
  // Let falling edges pass.
  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One access; released data is inverted so stale bytes never look valid.
  task automatic xfer(input logic rs, input logic rd, input logic [7:0] wd,
                      output logic [7:0] q);
    @(negedge mclk);
    cs_n = 1'b0;
    reg_select_line = rs;
    db_in = wd;
    gap(1);
    strobe_e_rd = !rd;
    rw_wr = rd;
    gap(5);
    q = db_out;
    strobe_e_rd = 1'b1;
    rw_wr = 1'b1;
    gap(4);
    cs_n = 1'b1;
    db_in = ~wd;
    gap(4);
  endtask
  // One 68-style access: R/W set up first, then an enable pulse held high.
  task automatic xfer68(input logic rs, input logic rd, input logic [7:0] wd,
                        output logic [7:0] q);
    @(negedge mclk);
    cs_n = 1'b0;
    reg_select_line = rs;
    rw_wr = rd;
    db_in = wd;
    gap(1);
    strobe_e_rd = 1'b1;
    gap(5);
    q = db_out;
    strobe_e_rd = 1'b0;
    gap(4);
    cs_n = 1'b1;
    rw_wr = 1'b1;
    db_in = ~wd;
    gap(4);
  endtask
endmodule // lcdcd_host

/* File: dv/tb_lcdcd_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("ERROR %0t got %h expected %h", $time, got, exp); \
    end \
  end
// Bench for the decoder, driven through the host model.
module tb_lcdcd_top;
  import lcdcd_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  wire init_pin, cs_n, reg_select_line, strobe_e_rd, rw_wr;
  wire [7:0] db_in;
  logic [7:0] db_out;
  logic db_oe_n, disp_on, static_on, power_save, order_fwd;
  logic [4:0] first_row_line, row_span;
  logic [1:0] page_out;
  int failures = 0;
  int n_compared = 0;
  logic [7:0] d;
  // Opcode and expected {disp, static, save, forward, span} after it.
  logic [16:0] tab [10] = '{{8'haf, 4'h9, 5'h4}, {8'ha5, 4'hd, 5'h4}, {8'hae, 4'h7, 5'h4},
    {8'ha4, 4'h1, 5'h4}, {8'ha8, 4'h1, 5'h3}, {8'ha1, 4'h0, 5'h3}, {8'hef, 4'h0, 5'h3},
    {8'ha0, 4'h1, 5'h3}, {8'ha9, 4'h1, 5'h4}, {8'haf, 4'h9, 5'h4}};
  always #2.5 mclk = ~mclk;
  lcdcd_top i_dut (.mclk(mclk), .arst_n(arst_n), .init_pin(init_pin), .cs_n(cs_n),
    .reg_select_line(reg_select_line), .strobe_e_rd(strobe_e_rd), .rw_wr(rw_wr),
    .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n), .first_row_line(first_row_line),
    .row_span(row_span), .disp_on(disp_on), .static_on(static_on),
    .power_save(power_save), .order_fwd(order_fwd), .page_out(page_out));
  lcdcd_host i_host (.mclk(mclk), .db_out(db_out), .init_pin(init_pin), .cs_n(cs_n),
    .reg_select_line(reg_select_line), .strobe_e_rd(strobe_e_rd), .rw_wr(rw_wr),
    .db_in(db_in));
  // Mode outputs packed like the table rows.
  function automatic logic [8:0] modes();
    return {disp_on, static_on, power_save, order_fwd, row_span};
  endfunction
  task automatic cmd(input logic [7:0] op);
    i_host.xfer(1'b0, 1'b0, op, d);
  endtask
  task automatic wrd(input logic [7:0] v);
    i_host.xfer(1'b1, 1'b0, v, d);
  endtask
  task automatic rdd(input logic rs);
    i_host.xfer(rs, 1'b1, 8'h00, d);
  endtask
  // Reset values, status, and a write landing at column zero.
  task automatic t_reset();
    `CHK({first_row_line, page_out}, {LINE_RESET, PAGE_RESET})
    `CHK(modes(), {4'h1, 5'h4})
    rdd(1'b0);
    `CHK(d, 8'h60)
    wrd(8'h3c);
    cmd(8'h00);
    rdd(1'b1);
    rdd(1'b1);
    `CHK(d, 8'h3c)
  endtask
  // Each display, order, static and duty command, an unknown byte among them, with status after each.
  task automatic t_modes();
    for (int i = 0; i < 10; i++)
    begin
      cmd(tab[i][16:9]);
      `CHK(modes(), tab[i][8:0])
      rdd(1'b0);
      `CHK(d, {1'b0, tab[i][5], ~tab[i][8], 5'h00})
    end
  endtask
  // Line and page loads, then a soft reset that keeps the modes.
  task automatic t_line_page();
    cmd(8'hdf);
    cmd(8'hbb);
    `CHK({first_row_line, page_out}, {5'h1f, 2'h3})
    `CHK(modes(), {4'h9, 5'h4})
    cmd(8'he2);
    i_host.gap(10);
    `CHK({first_row_line, page_out}, {LINE_RESET, PAGE_RESET})
    `CHK(modes(), {4'h9, 5'h4})
  endtask
  // Column limit and page separation.
  task automatic t_data();
    cmd(8'h4f);
    wrd(8'hc3);
    wrd(8'h99);
    cmd(8'hb9);
    cmd(8'h4f);
    wrd(8'h77);
    cmd(8'hb8);
    cmd(8'h4f);
    rdd(1'b1);
    rdd(1'b1);
    `CHK(d, 8'hc3)
  endtask
  // Read-modify-write: reads hold the column, End restores it.
  task automatic t_rmw();
    cmd(8'h05);
    wrd(8'h11);
    wrd(8'h22);
    cmd(8'h05);
    cmd(8'he0);
    rdd(1'b1);
    rdd(1'b1);
    `CHK(d, 8'h11)
    rdd(1'b1);
    `CHK(d, 8'h11)
    wrd(8'h33);
    cmd(8'hee);
    rdd(1'b1);
    rdd(1'b1);
    `CHK(d, 8'h33)
    rdd(1'b1);
    `CHK(d, 8'h22)
  endtask
  // Mid-run reset into the 68 style: status, a column load and a read back.
  task automatic t_style68();
    @(negedge mclk);
    arst_n = 1'b0;
    i_host.init_pin = 1'b1;
    i_host.strobe_e_rd = 1'b0;
    i_host.gap(4);
    arst_n = 1'b1;
    i_host.gap(12);
    `CHK(modes(), {4'h1, 5'h4})
    i_host.xfer68(1'b0, 1'b1, 8'h00, d);
    `CHK(d, 8'h60)
    i_host.xfer68(1'b0, 1'b0, 8'h05, d);
    i_host.xfer68(1'b1, 1'b1, 8'h00, d);
    i_host.xfer68(1'b1, 1'b1, 8'h00, d);
    `CHK(d, 8'h33)
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    i_host.gap(12);
    t_reset();
    t_modes();
    t_line_page();
    t_data();
    t_rmw();
    t_style68();
    wrap_up();
  end
  // The tests take about 870 cycles; 15000, some seventeen times that, means a hang.
  initial
  begin
    #75000;
    failures++;
    wrap_up();
  end
endmodule // tb_lcdcd_top
